// >>> sbbe_defs.vh
// constants for the shift, branch and bit-field execute block
`ifndef SBBE_DEFS_VH
`define SBBE_DEFS_VH
`define SBBE_SHIFT_TYPE_ASR 2'h2
`define SBBE_COND_UNDEF 4'hE
`define SBBE_COND_SVC 4'hF
`define SBBE_REG_SP 4'hD
`define SBBE_REG_PC 4'hF
`define SBBE_SHIFT_FULL 8'h20
`define SBBE_ENC_ASR_IMM16 5'h02
`define SBBE_ENC_ASR_REG16 10'h104
`define SBBE_ENC_BR_COND16 4'hD
`define SBBE_ENC_BR_UNC16 5'h1C
`define SBBE_ENC_ASR_IMM32 11'h752
`define SBBE_ENC_ASR_REG32 11'h7D2
`define SBBE_ENC_PFX32 5'h1E
`define SBBE_ENC_BR32_HI 2'h2
`define SBBE_ENC_FIELD 6'h36
`define SBBE_OP_NONE 4'h0
`define SBBE_OP_ASR_IMM16 4'h1
`define SBBE_OP_ASR_IMM32 4'h2
`define SBBE_OP_ASR_REG16 4'h3
`define SBBE_OP_ASR_REG32 4'h4
`define SBBE_OP_BR_COND16 4'h5
`define SBBE_OP_BR_UNC16 4'h6
`define SBBE_OP_BR_COND32 4'h7
`define SBBE_OP_BR_UNC32 4'h8
`define SBBE_OP_FIELD 4'h9
`define SBBE_OP_SVC 4'hA
`define SBBE_OP_UNDEF 4'hB
`define SBBE_OP_OTHER 4'hC
`endif

// >>> sbbe_asr.v
// arithmetic shift right with carry out
`timescale 1ns/1ps
`default_nettype none
`include "sbbe_defs.vh"
module sbbe_asr (
   input wire [31:0] value_i,
   input wire [7:0] amount_i,
   input wire carry_i,
   output reg [31:0] result_o,
   output reg carry_o
);
   reg [63:0] ext;
   reg [64:0] sh;
   always @* begin
      ext = {{32{value_i[31]}}, value_i};
      sh = 65'h0;
      result_o = value_i;
      carry_o = carry_i;
      if (amount_i == 8'h00) begin
         result_o = value_i;
         carry_o = carry_i;
      end else if (amount_i >= `SBBE_SHIFT_FULL) begin
         result_o = {32{value_i[31]}};
         carry_o = value_i[31];
      end else begin
         // spare low bit catches the last bit shifted out as carry
         sh = {ext, 1'b0} >> amount_i;
         result_o = sh[32:1];
         carry_o = sh[0];
      end
   end
endmodule // sbbe_asr
`default_nettype wire

// >>> sbbe_exec.v
// decode and execute for arithmetic shift right, pc-relative branch and bit-field ops
`timescale 1ns/1ps
`default_nettype none
`include "sbbe_defs.vh"
// Contract
// [RULE1] immediate shift moves source right, filling with bit 31, writes destination
// [RULE2] 16-bit immediate form uses five-bit amount as arithmetic shift
// [RULE3] 32-bit immediate amount is high three bits then low two bits
// [RULE4] 16-bit forms update flags only outside a predicated group
// [RULE5] flag update sets N, Z, C from result; V unchanged
// [RULE6] register shift amount is low byte of amount register, unsigned
// [RULE7] 32-bit shifts with register 13 or 15 are unpredictable
// [RULE8] short conditional branch: code 1110 undefined, 1111 supervisor call
// [RULE9] short conditional offset is eight-bit field, zero appended, sign-extended
// [RULE10] short unconditional offset is eleven-bit field, zero appended, sign-extended
// [RULE11] long branch upper bits are inverted xor of hop bits with sign
// [RULE12] branches carrying own predicate are unpredictable inside a predicated group
// [RULE13] unconditional branches unpredictable inside a group unless last
// [RULE14] taken branch writes program counter plus offset
// [RULE15] offsets are even and within each encoding's signed range
// [RULE16] long conditional branch with code 1110 or 1111 is another instruction
// [RULE17] field clear zeroes bits bottom to top inclusive, others kept
// [RULE18] clear positions from top field and three-plus-two bottom parts
// [RULE19] field insert copies low source bits into destination range
// [RULE20] top below bottom is unpredictable for both field ops
// [RULE21] field insert with source 1111 decodes as field clear
// [RULE22] field insert unpredictable for destination 13 or 15, source 13
// [RULE23] immediate amount zero means shift by 32
// [RULE24] register shift of 32 or more gives sign copies; zero keeps value
module sbbe_exec (
   input wire clk_i,
   input wire rst_i,
   input wire valid_i,
   input wire [31:0] instr_i,
   input wire wide_i,
   input wire in_group_i,
   input wire last_in_group_i,
   input wire cond_pass_i,
   input wire [31:0] pc_i,
   input wire [31:0] rd_val_i,
   input wire [31:0] rn_val_i,
   input wire [31:0] rm_val_i,
   input wire [3:0] flags_i,
   output reg [3:0] rd_idx_o,
   output reg [3:0] rn_idx_o,
   output reg [3:0] rm_idx_o,
   output reg done_o,
   output reg reg_wr_o,
   output reg [3:0] reg_wr_idx_o,
   output reg [31:0] reg_wr_data_o,
   output reg flags_wr_o,
   output reg [3:0] flags_o,
   output reg pc_wr_o,
   output reg [31:0] pc_next_o,
   output reg undef_o,
   output reg supervisor_call_o,
   output reg unpredictable_o,
   output reg other_instr_o
);
   // 16-bit forms sit in instr_i[15:0]; 32-bit forms have first halfword in [31:16]
   wire [15:0] hw = instr_i[15:0];
   wire [15:0] h1 = instr_i[31:16];
   wire [15:0] h2 = instr_i[15:0];
   reg [3:0] op;
   reg [3:0] d_idx;
   reg [3:0] n_idx;
   reg [3:0] m_idx;
   reg [7:0] amount;
   reg [31:0] shift_in;
   reg setflags;
   reg unpred;
   reg [31:0] offset;
   reg [3:0] cond;
   reg [4:0] msbit;
   reg [4:0] lsbit;
   reg clear_only;
   reg sign_b;
   reg i1;
   reg i2;
   wire [31:0] asr_res;
   wire asr_carry;
   reg [31:0] field_mask;
   reg [31:0] field_res;
   reg cond_ok;
   integer k;

   // named instruction fields
   wire [4:0] shift_amount_field = hw[10:6];
   wire [2:0] hi_shift_part = h2[14:12];
   wire [1:0] lo_shift_part = h2[7:6];
   wire [4:0] split_amount = {hi_shift_part, lo_shift_part};
   wire [7:0] short_offset_field = hw[7:0];
   wire [10:0] low_offset_field = h2[10:0];
   wire [9:0] upper_offset_field = h1[9:0];
   wire [5:0] mid_offset_field = h1[5:0];
   wire hop_bit_one = h2[13];
   wire hop_bit_two = h2[11];

   // encoding matches; the 32-bit shift patterns stop short of the flag update bit
   wire m_asr_imm16 = (hw[15:11] == `SBBE_ENC_ASR_IMM16);
   wire m_asr_reg16 = (hw[15:6] == `SBBE_ENC_ASR_REG16);
   wire m_br_cond16 = (hw[15:12] == `SBBE_ENC_BR_COND16);
   wire m_br_unc16 = (hw[15:11] == `SBBE_ENC_BR_UNC16);
   wire m_asr_imm32 = (h1[15:5] == `SBBE_ENC_ASR_IMM32) && (h1[3:0] == `SBBE_REG_PC) &&
      (h2[5:4] == `SBBE_SHIFT_TYPE_ASR);
   wire m_asr_reg32 = (h1[15:5] == `SBBE_ENC_ASR_REG32) && (h2[15:12] == 4'hF) &&
      (h2[7:4] == 4'h0);
   wire m_pfx32 = (h1[15:11] == `SBBE_ENC_PFX32);
   wire m_br32 = m_pfx32 && (h2[15:14] == `SBBE_ENC_BR32_HI);
   wire m_br_cond32 = m_br32 && !h2[12];
   wire m_br_unc32 = m_br32 && h2[12];
   wire m_field = m_pfx32 && (h1[9:4] == `SBBE_ENC_FIELD) && !h2[15];

   // program flags word is {N, Z, C, V}
   wire flag_n = flags_i[3];
   wire flag_z = flags_i[2];
   wire flag_c = flags_i[1];
   wire flag_v = flags_i[0];

   // operation select from encoding
   always @* begin
      op = `SBBE_OP_NONE;
      if (valid_i) begin
         if (!wide_i) begin
            if (m_asr_imm16)
               op = `SBBE_OP_ASR_IMM16;
            else if (m_asr_reg16)
               op = `SBBE_OP_ASR_REG16;
            else if (m_br_cond16) begin
               if (hw[11:8] == `SBBE_COND_UNDEF) // [RULE8]
                  op = `SBBE_OP_UNDEF;
               else if (hw[11:8] == `SBBE_COND_SVC) // [RULE8]
                  op = `SBBE_OP_SVC;
               else
                  op = `SBBE_OP_BR_COND16;
            end else if (m_br_unc16)
               op = `SBBE_OP_BR_UNC16;
         end else begin
            if (m_asr_imm32)
               op = `SBBE_OP_ASR_IMM32;
            else if (m_asr_reg32)
               op = `SBBE_OP_ASR_REG32;
            else if (m_br_cond32) begin
               if (h1[9:7] == 3'h7) // [RULE16]
                  op = `SBBE_OP_OTHER;
               else
                  op = `SBBE_OP_BR_COND32;
            end else if (m_br_unc32)
               op = `SBBE_OP_BR_UNC32;
            else if (m_field)
               op = `SBBE_OP_FIELD;
         end
      end
   end

   // field extraction and unpredictable checks
   always @* begin
      d_idx = 4'h0;
      n_idx = 4'h0;
      m_idx = 4'h0;
      amount = 8'h00;
      shift_in = rm_val_i;
      setflags = 1'b0;
      unpred = 1'b0;
      offset = 32'h0;
      cond = 4'hE;
      msbit = h2[4:0]; // [RULE18]
      lsbit = split_amount; // [RULE18]
      clear_only = (h1[3:0] == `SBBE_REG_PC); // [RULE21]
      sign_b = h1[10];
      i1 = ~(hop_bit_one ^ sign_b); // [RULE11]
      i2 = ~(hop_bit_two ^ sign_b); // [RULE11]
      case (op)
         `SBBE_OP_ASR_IMM16: begin
            d_idx = {1'b0, hw[2:0]};
            m_idx = {1'b0, hw[5:3]};
            amount = (shift_amount_field == 5'h00) ? `SBBE_SHIFT_FULL :
               {3'h0, shift_amount_field}; // [RULE2] [RULE23]
            setflags = ~in_group_i; // [RULE4]
         end
         `SBBE_OP_ASR_REG16: begin
            d_idx = {1'b0, hw[2:0]};
            n_idx = {1'b0, hw[2:0]};
            m_idx = {1'b0, hw[5:3]};
            shift_in = rn_val_i;
            amount = rm_val_i[7:0]; // [RULE6]
            setflags = ~in_group_i; // [RULE4]
         end
         `SBBE_OP_ASR_IMM32: begin
            d_idx = h2[11:8];
            m_idx = h2[3:0];
            amount = (split_amount == 5'h00) ? `SBBE_SHIFT_FULL :
               {3'h0, split_amount}; // [RULE3] [RULE23]
            setflags = h1[4];
            unpred = (d_idx == `SBBE_REG_SP) || (d_idx == `SBBE_REG_PC) ||
               (m_idx == `SBBE_REG_SP) || (m_idx == `SBBE_REG_PC); // [RULE7]
         end
         `SBBE_OP_ASR_REG32: begin
            d_idx = h2[11:8];
            n_idx = h1[3:0];
            m_idx = h2[3:0];
            shift_in = rn_val_i;
            amount = rm_val_i[7:0]; // [RULE6]
            setflags = h1[4];
            unpred = (d_idx == `SBBE_REG_SP) || (d_idx == `SBBE_REG_PC) ||
               (n_idx == `SBBE_REG_SP) || (n_idx == `SBBE_REG_PC) ||
               (m_idx == `SBBE_REG_SP) || (m_idx == `SBBE_REG_PC); // [RULE7]
         end
         `SBBE_OP_BR_COND16: begin
            cond = hw[11:8];
            offset = {{23{short_offset_field[7]}}, short_offset_field, 1'b0}; // [RULE9] [RULE15]
            unpred = in_group_i; // [RULE12]
         end
         `SBBE_OP_BR_UNC16: begin
            offset = {{20{low_offset_field[10]}}, low_offset_field, 1'b0}; // [RULE10] [RULE15]
            unpred = in_group_i && !last_in_group_i; // [RULE13]
         end
         `SBBE_OP_BR_COND32: begin
            cond = h1[9:6];
            // short long form: hop bits sit directly, no inversion
            offset = {{12{sign_b}}, hop_bit_two, hop_bit_one, mid_offset_field,
               low_offset_field, 1'b0}; // [RULE15]
            unpred = in_group_i; // [RULE12]
         end
         `SBBE_OP_BR_UNC32: begin
            offset = {{8{sign_b}}, i1, i2, upper_offset_field,
               low_offset_field, 1'b0}; // [RULE11] [RULE15]
            unpred = in_group_i && !last_in_group_i; // [RULE13]
         end
         `SBBE_OP_FIELD: begin
            d_idx = h2[11:8];
            n_idx = h1[3:0];
            unpred = (d_idx == `SBBE_REG_SP) || (d_idx == `SBBE_REG_PC) ||
               (msbit < lsbit); // [RULE18] [RULE20]
            if (!clear_only && n_idx == `SBBE_REG_SP)
               unpred = 1'b1; // [RULE22]
         end
         default: begin
            d_idx = 4'h0;
         end
      endcase
   end

   sbbe_asr u_asr (
      .value_i(shift_in),
      .amount_i(amount),
      .carry_i(flag_c),
      .result_o(asr_res), // [RULE1] [RULE24]
      .carry_o(asr_carry)
   );

   // field mask and merge
   always @* begin
      field_mask = 32'h0;
      field_res = rd_val_i;
      for (k = 0; k < 32; k = k + 1) begin
         if (k >= lsbit && k <= msbit)
            field_mask[k] = 1'b1;
      end
      if (clear_only)
         field_res = rd_val_i & ~field_mask; // [RULE17]
      else
         field_res = (rd_val_i & ~field_mask) | ((rn_val_i << lsbit) & field_mask); // [RULE19]
   end

   // embedded branch condition against flags N Z C V (bits 3..0)
   always @* begin
      case (cond[3:1])
         3'h0: cond_ok = flag_z;
         3'h1: cond_ok = flag_c;
         3'h2: cond_ok = flag_n;
         3'h3: cond_ok = flag_v;
         3'h4: cond_ok = flag_c & ~flag_z;
         3'h5: cond_ok = (flag_n == flag_v);
         3'h6: cond_ok = ~flag_z & (flag_n == flag_v);
         default: cond_ok = 1'b1;
      endcase
      if (cond[0] && cond != 4'hF)
         cond_ok = ~cond_ok;
   end

   wire is_shift = (op == `SBBE_OP_ASR_IMM16) || (op == `SBBE_OP_ASR_IMM32) ||
      (op == `SBBE_OP_ASR_REG16) || (op == `SBBE_OP_ASR_REG32);
   wire is_branch = (op == `SBBE_OP_BR_COND16) || (op == `SBBE_OP_BR_UNC16) ||
      (op == `SBBE_OP_BR_COND32) || (op == `SBBE_OP_BR_UNC32);
   wire own_cond = (op == `SBBE_OP_BR_COND16) || (op == `SBBE_OP_BR_COND32);
   wire exec_ok = cond_pass_i && !unpred;

   // unpredictable words commit nothing: a safe choice that keeps state intact
   always @(posedge clk_i) begin
      if (rst_i) begin
         rd_idx_o <= 4'h0;
         rn_idx_o <= 4'h0;
         rm_idx_o <= 4'h0;
         done_o <= 1'b0;
         reg_wr_o <= 1'b0;
         reg_wr_idx_o <= 4'h0;
         reg_wr_data_o <= 32'h0;
         flags_wr_o <= 1'b0;
         flags_o <= 4'h0;
         pc_wr_o <= 1'b0;
         pc_next_o <= 32'h0;
         undef_o <= 1'b0;
         supervisor_call_o <= 1'b0;
         unpredictable_o <= 1'b0;
         other_instr_o <= 1'b0;
      end else begin
         rd_idx_o <= d_idx;
         rn_idx_o <= n_idx;
         rm_idx_o <= m_idx;
         done_o <= (op != `SBBE_OP_NONE);
         reg_wr_o <= 1'b0;
         reg_wr_idx_o <= d_idx;
         reg_wr_data_o <= 32'h0;
         flags_wr_o <= 1'b0;
         flags_o <= flags_i;
         pc_wr_o <= 1'b0;
         pc_next_o <= pc_i;
         undef_o <= (op == `SBBE_OP_UNDEF); // [RULE8]
         supervisor_call_o <= (op == `SBBE_OP_SVC); // [RULE8]
         unpredictable_o <= unpred;
         other_instr_o <= (op == `SBBE_OP_OTHER); // [RULE16]
         if (is_shift && exec_ok) begin
            reg_wr_o <= 1'b1;
            reg_wr_data_o <= asr_res; // [RULE1]
            if (setflags) begin
               flags_wr_o <= 1'b1;
               flags_o <= {asr_res[31], (asr_res == 32'h0), asr_carry, flag_v}; // [RULE5]
            end
         end
         if (is_branch && !unpred && (own_cond ? cond_ok : cond_pass_i)) begin
            pc_wr_o <= 1'b1;
            pc_next_o <= pc_i + offset; // [RULE14]
         end
         if (op == `SBBE_OP_FIELD && exec_ok) begin
            reg_wr_o <= 1'b1;
            reg_wr_data_o <= field_res; // [RULE17] [RULE19]
         end
      end
   end
endmodule // sbbe_exec
`default_nettype wire

// >>> sbbe_exec_props.sv
// assertion checker for the shift, branch and bit-field execute block
`timescale 1ns/1ps
`default_nettype none
module sbbe_exec_props (
   input wire clk_i,
   input wire rst_i,
   input wire valid_i,
   input wire [31:0] instr_i,
   input wire wide_i,
   input wire in_group_i,
   input wire cond_pass_i,
   input wire [31:0] pc_i,
   input wire [3:0] flags_i,
   input wire [31:0] reg_wr_data_o,
   input wire reg_wr_o,
   input wire flags_wr_o,
   input wire [3:0] flags_o,
   input wire pc_wr_o,
   input wire [31:0] pc_next_o,
   input wire undef_o,
   input wire supervisor_call_o,
   input wire unpredictable_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   wire narrow = valid_i && !wide_i;
   // target of the short unconditional form, compared one cycle later
   wire [31:0] tgt16 = pc_i + {{20{instr_i[10]}}, instr_i[10:0], 1'b0};
   wire b16 = narrow && instr_i[15:11] == 5'h1C && !in_group_i && cond_pass_i;
   wire cond_bad = instr_i[31:27] == 5'h1E && instr_i[15:14] == 2'h2 && !instr_i[12];
   property p_nocommit;
      unpredictable_o |-> !reg_wr_o && !pc_wr_o && !flags_wr_o;
   endproperty
   a_nocommit: assert property (p_nocommit) else $error("unpredictable word committed");
   property p_undef;
      narrow && !in_group_i && instr_i[15:8] == 8'hDE |=> undef_o && !pc_wr_o;
   endproperty
   a_undef: assert property (p_undef) else $error("reserved code not undefined");
   property p_svc;
      narrow && !in_group_i && instr_i[15:8] == 8'hDF |=> supervisor_call_o && !pc_wr_o;
   endproperty
   a_svc: assert property (p_svc) else $error("call code not decoded");
   property p_grp_flags;
      narrow && instr_i[15:11] == 5'h02 && in_group_i |=> !flags_wr_o;
   endproperty
   a_grp_flags: assert property (p_grp_flags) else $error("flags written in group");
   property p_flag_val;
      flags_wr_o |-> flags_o[0] == $past(flags_i[0]) && flags_o[3] == reg_wr_data_o[31]
         && flags_o[2] == (reg_wr_data_o == 32'h0);
   endproperty
   a_flag_val: assert property (p_flag_val) else $error("flag values wrong");
   property p_b16;
      b16 |=> pc_wr_o && pc_next_o == $past(tgt16);
   endproperty
   a_b16: assert property (p_b16) else $error("short branch target wrong");
   property p_b32_other;
      valid_i && wide_i && cond_bad && instr_i[25:23] == 3'h7 |=> !pc_wr_o;
   endproperty
   a_b32_other: assert property (p_b32_other) else $error("reserved code branched");
   property p_even;
      pc_wr_o |-> pc_next_o[0] == $past(pc_i[0]);
   endproperty
   a_even: assert property (p_even) else $error("odd branch offset");
endmodule // sbbe_exec_props
bind sbbe_exec sbbe_exec_props u_props (.clk_i(clk_i), .rst_i(rst_i), .valid_i(valid_i),
   .instr_i(instr_i), .wide_i(wide_i), .in_group_i(in_group_i), .cond_pass_i(cond_pass_i),
   .pc_i(pc_i), .flags_i(flags_i), .reg_wr_data_o(reg_wr_data_o), .reg_wr_o(reg_wr_o),
   .flags_wr_o(flags_wr_o), .flags_o(flags_o), .pc_wr_o(pc_wr_o), .pc_next_o(pc_next_o),
   .undef_o(undef_o), .supervisor_call_o(supervisor_call_o),
   .unpredictable_o(unpredictable_o));
`default_nettype wire

// >>> sbbe_exec_tb.sv
// self-checking testbench for the shift, branch and bit-field execute block
`timescale 1ns/1ps
`default_nettype none
module sbbe_exec_tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic valid_i = 1'b0;
   logic wide_i = 1'b0;
   logic in_group_i = 1'b0;
   logic last_in_group_i = 1'b0;
   logic cond_pass_i = 1'b1;
   logic [31:0] instr_i = 32'h0;
   logic [31:0] pc_i = 32'h0;
   logic [31:0] rd_val_i = 32'h0;
   logic [31:0] rn_val_i = 32'h0;
   logic [31:0] rm_val_i = 32'h0;
   logic [3:0] flags_i = 4'h0;
   wire [3:0] rd_idx_o, rn_idx_o, rm_idx_o, reg_wr_idx_o, flags_o;
   wire done_o, reg_wr_o, flags_wr_o, pc_wr_o, undef_o, supervisor_call_o;
   wire unpredictable_o, other_instr_o;
   wire [31:0] reg_wr_data_o, pc_next_o;
   int failures = 0;
   int cmp_count = 0;
   sbbe_exec dut (.clk_i(clk_i), .rst_i(rst_i), .valid_i(valid_i), .instr_i(instr_i),
      .wide_i(wide_i), .in_group_i(in_group_i), .last_in_group_i(last_in_group_i),
      .cond_pass_i(cond_pass_i), .pc_i(pc_i), .rd_val_i(rd_val_i), .rn_val_i(rn_val_i),
      .rm_val_i(rm_val_i), .flags_i(flags_i), .rd_idx_o(rd_idx_o), .rn_idx_o(rn_idx_o),
      .rm_idx_o(rm_idx_o), .done_o(done_o), .reg_wr_o(reg_wr_o), .reg_wr_idx_o(reg_wr_idx_o),
      .reg_wr_data_o(reg_wr_data_o), .flags_wr_o(flags_wr_o), .flags_o(flags_o),
      .pc_wr_o(pc_wr_o), .pc_next_o(pc_next_o), .undef_o(undef_o),
      .supervisor_call_o(supervisor_call_o), .unpredictable_o(unpredictable_o),
      .other_instr_o(other_instr_o));
   always #20 clk_i = ~clk_i;
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
      end
   endtask
   task automatic chk_b(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
      end
   endtask
   // one word in, answer sampled just after the taking edge has landed
   task automatic exec(input logic [31:0] w, input logic wd, input logic g, input logic l,
      input logic [31:0] rd, input logic [31:0] rn, input logic [31:0] rm,
      input logic [3:0] f, input logic [31:0] pc);
      @(posedge clk_i);
      instr_i <= w;
      wide_i <= wd;
      in_group_i <= g;
      last_in_group_i <= l;
      rd_val_i <= rd;
      rn_val_i <= rn;
      rm_val_i <= rm;
      flags_i <= f;
      pc_i <= pc;
      valid_i <= 1'b1;
      @(posedge clk_i);
      valid_i <= 1'b0;
      #1;
   endtask
   task automatic wr(input logic [31:0] d, input logic fw, input logic [3:0] f);
      chk_b(reg_wr_o, 1'b1);
      chk_w(reg_wr_data_o, d);
      chk_b(flags_wr_o, fw);
      if (fw) chk_w({28'h0, flags_o}, {28'h0, f});
   endtask
   task automatic br(input logic [31:0] t);
      chk_b(pc_wr_o, 1'b1);
      chk_w(pc_next_o, t);
   endtask
   task automatic bad;
      chk_b(unpredictable_o, 1'b1);
      chk_b(reg_wr_o | pc_wr_o | flags_wr_o, 1'b0);
   endtask
   initial begin
      #200000;
      failures++;
      close_out();
   end
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      chk_b(done_o | reg_wr_o | pc_wr_o, 1'b0);
      exec(32'h1048, 0, 0, 0, 0, 0, 32'h80000010, 4'h1, 0);
      wr(32'hC0000008, 1, 4'h9);
      chk_w({28'h0, reg_wr_idx_o}, 32'h0);
      chk_b(done_o, 1'b1);
      exec(32'h1048, 0, 1, 0, 0, 0, 32'h80000010, 4'h1, 0);
      wr(32'hC0000008, 0, 4'h0);
      exec(32'h1008, 0, 0, 0, 0, 0, 32'h80000000, 4'h0, 0);
      wr(32'hFFFFFFFF, 1, 4'hA);
      exec(32'hEA5F1263, 1, 0, 0, 0, 0, 32'h80000000, 4'h1, 0);
      wr(32'hFC000000, 1, 4'h9);
      chk_w({28'h0, reg_wr_idx_o}, 32'h2);
      exec(32'hEA4F1263, 1, 0, 0, 0, 0, 32'h80000000, 4'h1, 0);
      wr(32'hFC000000, 0, 4'h0);
      exec(32'hEA5F1D63, 1, 0, 0, 0, 0, 32'h80000000, 4'h1, 0);
      bad();
      exec(32'hFA51F203, 1, 0, 0, 0, 32'hF0000000, 32'h104, 4'h0, 0);
      wr(32'hFF000000, 1, 4'h8);
      exec(32'hFA51F203, 1, 0, 0, 0, 32'h80000000, 32'h28, 4'h0, 0);
      wr(32'hFFFFFFFF, 1, 4'hA);
      exec(32'hFA51F203, 1, 0, 0, 0, 32'h12345678, 32'h100, 4'h2, 0);
      wr(32'h12345678, 1, 4'h2);
      exec(32'h410A, 0, 0, 0, 0, 32'h80000000, 32'h11F, 4'h0, 0);
      wr(32'hFFFFFFFF, 1, 4'h8);
      chk_w({24'h0, rd_idx_o, rn_idx_o}, 32'h22);
      chk_w({28'h0, rm_idx_o}, 32'h1);
      exec(32'h0000, 0, 0, 0, 0, 0, 0, 4'h0, 0);
      chk_b(done_o | reg_wr_o, 1'b0);
      exec(32'hD0FF, 0, 0, 0, 0, 0, 0, 4'h4, 32'h1000);
      br(32'h0FFE);
      exec(32'hD1FF, 0, 0, 0, 0, 0, 0, 4'h4, 32'h1000);
      chk_b(pc_wr_o, 1'b0);
      exec(32'hDE00, 0, 0, 0, 0, 0, 0, 4'h4, 32'h1000);
      chk_b(undef_o, 1'b1);
      exec(32'hDF00, 0, 0, 0, 0, 0, 0, 4'h4, 32'h1000);
      chk_b(supervisor_call_o, 1'b1);
      exec(32'hD0FF, 0, 1, 1, 0, 0, 0, 4'h4, 32'h1000);
      bad();
      exec(32'hE400, 0, 0, 0, 0, 0, 0, 4'h0, 32'h1000);
      br(32'h0800);
      exec(32'hE400, 0, 1, 0, 0, 0, 0, 4'h0, 32'h1000);
      bad();
      exec(32'hE400, 0, 1, 1, 0, 0, 0, 4'h0, 32'h1000);
      br(32'h0800);
      exec(32'hF0009000, 1, 0, 0, 0, 0, 0, 4'h0, 32'h1000);
      br(32'h00C01000);
      exec(32'hF4009000, 1, 0, 0, 0, 0, 0, 4'h0, 32'h01001000);
      br(32'h00001000);
      exec(32'hF0008001, 1, 0, 0, 0, 0, 0, 4'h4, 32'h1000);
      br(32'h1002);
      exec(32'hF3808000, 1, 0, 0, 0, 0, 0, 4'h4, 32'h1000);
      chk_b(pc_wr_o, 1'b0);
      chk_b(other_instr_o, 1'b1);
      exec(32'hF36F120B, 1, 0, 0, 32'hFFFFFFFF, 0, 0, 4'h0, 0);
      wr(32'hFFFFF00F, 0, 4'h0);
      exec(32'hF361120B, 1, 0, 0, 0, 32'hABC, 0, 4'h0, 0);
      wr(32'h00000BC0, 0, 4'h0);
      exec(32'hF361001F, 1, 0, 0, 0, 32'h12345678, 0, 4'h0, 0);
      wr(32'h12345678, 0, 4'h0);
      exec(32'hF3611203, 1, 0, 0, 0, 32'hABC, 0, 4'h0, 0);
      bad();
      exec(32'hF36D120B, 1, 0, 0, 0, 32'hABC, 0, 4'h0, 0);
      bad();
      exec(32'hF36F1D0B, 1, 0, 0, 32'hFFFFFFFF, 0, 0, 4'h0, 0);
      bad();
      close_out();
   end
endmodule // sbbe_exec_tb
`default_nettype wire
